// file: verilog/sucp_cfg_page.sv
// user configuration page with its two-wire serial register access
`include "sucp_defs.svh"
`default_nettype none

// Overview of operation
// R1: restore registers from memory on integrity fault
// R2: per-channel 2-bit result width field
// R3: per-channel 3-bit chopper field
// R4: per-channel filter and oversampling fields
// R5: merge bit: OR accumulate or replace
// R6: quick-wake keeps bias and oscillator powered
// R7: interrupt pin pulsed at 0, level at 1
// R8: hysteresis switch bit enables switch operation
// R9: output temperature select: A at 0
// R10: FIFO level interrupt at threshold, 0 off
// R11: FIFO policy: off, stop, overwrite
// R12: interval field paces autonomous mode, 0 off
// R13: interval from end to start; immediate start
// R14: DAC source: pressure 0, temperature 1
// R15: chain-mode bit selects daisy-chain link mode
// R16: spike filter enable, defaults to on
// R17: address bits from field, LSB inverted select
// R18: global gate masks every interrupt
// R19: link checksum checked and appended when enabled
// R20: memory checksum enable runs integrity check
// R21: three error classes each gated separately
// R22: other fields reset to zero
module sucp_cfg_page #(
	parameter int unsigned STEP_CYCLES =
		`SUCP_DELAY_STEP_S * `SUCP_CLK_HZ
) (
	// system clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// two-wire serial link
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	input wire logic chip_select_pin,
	// nonvolatile image and integrity check
	input wire logic [7:0][15:0] nvm_image,
	input wire logic conv_req,
	input wire logic mem_crc_fail,
	// measurement datapath
	input wire logic meas_done,
	input wire logic [5:0] fifo_count,
	input wire sucp_pkg::sucp_evt_t evt,
	input wire logic int_clear,
	// configuration and status
	output sucp_pkg::sucp_cfg_t cfg,
	output logic [6:0] dev_addr,
	output logic auto_start,
	output logic fifo_enable,
	output logic fifo_overwrite,
	output logic int_pin
);

	function automatic logic [15:0] wmask(input logic [2:0] idx);
		if (idx == `SUCP_IDX_DIG) begin
			wmask = `SUCP_MASK_DIG;
		end else if (idx == `SUCP_IDX_OPERATING_CONFIG) begin
			wmask = `SUCP_MASK_OPERATING_CONFIG;
		end else if (idx == `SUCP_IDX_DAC) begin
			wmask = `SUCP_MASK_DAC;
		end else if (idx == `SUCP_IDX_COM) begin
			wmask = `SUCP_MASK_COM;
		end else if (idx == `SUCP_IDX_INTEN) begin
			wmask = `SUCP_MASK_INTEN;
		end else begin
			wmask = `SUCP_MASK_MEAS;
		end
	endfunction : wmask

	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = `SUCP_CRC_INIT;
		for (int k = 15; k >= 0; k--) begin
			if (c[7] ^ d[k]) begin
				c = {c[6:0], 1'b0} ^ `SUCP_CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		crc8 = c;
	endfunction : crc8

	// system-domain pin synchronisers and frame tracking
	logic [2:0] scl_sy_ff;
	logic [2:0] sda_sy_ff;
	logic [1:0] csb_sy_ff;
	logic link_idle_ff;
	logic frame_start;
	logic frame_stop;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_sy_ff <= 3'h7;
			sda_sy_ff <= 3'h7;
			csb_sy_ff <= 2'h3;
		end else begin
			scl_sy_ff <= {scl_sy_ff[1:0], scl};
			sda_sy_ff <= {sda_sy_ff[1:0], sda_i};
			csb_sy_ff <= {csb_sy_ff[0], chip_select_pin};
		end
	end

	assign frame_start = scl_sy_ff[1] & scl_sy_ff[2] & sda_sy_ff[2]
		& ~sda_sy_ff[1];
	assign frame_stop = scl_sy_ff[1] & scl_sy_ff[2] & ~sda_sy_ff[2]
		& sda_sy_ff[1];

	// holds the link logic in reset between frames, since scl stops there
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			link_idle_ff <= 1'b1;
		end else if (frame_start) begin
			link_idle_ff <= 1'b0;
		end else if (frame_stop) begin
			link_idle_ff <= 1'b1;
		end
	end

	// write events arrive as a toggle; their data is held until the next
	logic wr_tog_ff;
	logic wr_kind_ff;
	logic [2:0] wr_idx_ff;
	logic [15:0] wr_data_ff;
	logic [2:0] wtg_sy_ff;
	logic wr_evt;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wtg_sy_ff <= 3'h0;
		end else begin
			wtg_sy_ff <= {wtg_sy_ff[1:0], wr_tog_ff};
		end
	end

	assign wr_evt = wtg_sy_ff[1] ^ wtg_sy_ff[2];

	// register words
	logic [15:0] cfg_w [`SUCP_NUM_REGS];
	logic reload_go;

	assign reload_go = conv_req & mem_crc_fail
		& cfg_w[`SUCP_IDX_INTEN][3'h2] & cfg_w[`SUCP_IDX_DIG][0]; // R1 R20

	for (genvar i = 0; i < `SUCP_NUM_REGS; i++) begin : g_word
		logic [15:0] word_ff;
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				if (3'(i) == `SUCP_IDX_COM) begin
					word_ff <= `SUCP_RST_COM; // R16 R17
				end else begin
					word_ff <= `SUCP_RST_ZERO; // R22
				end
			end else if (reload_go) begin
				word_ff <= nvm_image[i] & wmask(3'(i)); // R1
			end else if (wr_evt && wr_kind_ff && wr_idx_ff == 3'(i)) begin
				word_ff <= wr_data_ff & wmask(3'(i));
			end
		end
		assign cfg_w[i] = word_ff;
	end

	// field view of the words
	always_comb begin
		cfg.restore_on_fault = cfg_w[`SUCP_IDX_DIG][0];
		cfg.pres = sucp_pkg::sucp_meas_t'(cfg_w[`SUCP_IDX_PRES][11:0]); // R2
		cfg.temp_a = sucp_pkg::sucp_meas_t'(cfg_w[`SUCP_IDX_TEMPA][11:0]); // R3
		cfg.temp_b = sucp_pkg::sucp_meas_t'(cfg_w[`SUCP_IDX_TEMPB][11:0]); // R4
		cfg.operating_config = sucp_pkg::sucp_operating_config_t'(cfg_w[`SUCP_IDX_OPERATING_CONFIG]); // R6 R8 R9
		cfg.dac = sucp_pkg::sucp_dac_t'(cfg_w[`SUCP_IDX_DAC][13:0]); // R14
		cfg.com = sucp_pkg::sucp_com_t'(cfg_w[`SUCP_IDX_COM][7:0]); // R15 R16
		cfg.inten = sucp_pkg::sucp_inten_t'(cfg_w[`SUCP_IDX_INTEN][5:0]);
	end

	// read pointer and the word offered to the link
	logic [2:0] ptr_ff;
	logic [15:0] rd_word_ff;
	logic [7:0] rd_crc_ff;
	logic [6:0] dev_addr_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ptr_ff <= 3'h0;
			rd_word_ff <= 16'h0000;
			rd_crc_ff <= 8'h00;
			dev_addr_ff <= 7'h00;
		end else begin
			if (wr_evt) begin
				ptr_ff <= wr_idx_ff;
			end
			rd_word_ff <= cfg_w[ptr_ff];
			rd_crc_ff <= crc8(cfg_w[ptr_ff]); // R19
			dev_addr_ff <= {cfg.com.addr_hi, ~csb_sy_ff[1]}; // R17
		end
	end

	assign dev_addr = dev_addr_ff;

	// fifo controls and interrupt collection
	logic fifo_en_ff;
	logic fifo_ow_ff;
	logic thr_q_ff;
	logic thr_hit;
	logic [5:0] src;
	logic [5:0] pend_ff;
	logic int_pin_ff;

	assign thr_hit = (cfg.operating_config.fifo_irq_level != 5'h00)
		&& (fifo_count >= {1'b0, cfg.operating_config.fifo_irq_level}); // R10
	assign src = {evt.thr_evt, thr_hit & ~thr_q_ff, evt.adc_done,
		evt.adc_err & cfg.inten.adc_err_en,
		evt.calc_err & cfg.inten.calc_err_en,
		evt.sensor_err & cfg.inten.sensor_err_en}; // R21

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fifo_en_ff <= 1'b0;
			fifo_ow_ff <= 1'b0;
			thr_q_ff <= 1'b0;
		end else begin
			fifo_en_ff <= cfg.operating_config.fifo_policy != 2'h0; // R11
			fifo_ow_ff <= cfg.operating_config.fifo_policy[1]; // R11
			thr_q_ff <= thr_hit;
		end
	end

	// a new event wins over a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pend_ff <= 6'h00;
		end else if (cfg.operating_config.int_replace_mode) begin
			if (|src) begin
				pend_ff <= src; // R5
			end else if (int_clear) begin
				pend_ff <= 6'h00;
			end
		end else begin
			pend_ff <= (int_clear ? 6'h00 : pend_ff) | src; // R5
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			int_pin_ff <= 1'b0;
		end else if (!cfg.inten.global_int_en) begin
			int_pin_ff <= 1'b0; // R18
		end else if (cfg.operating_config.int_level_mode) begin
			int_pin_ff <= |pend_ff; // R7
		end else begin
			int_pin_ff <= |src; // R7
		end
	end

	assign fifo_enable = fifo_en_ff;
	assign fifo_overwrite = fifo_ow_ff;
	assign int_pin = int_pin_ff;

	// autonomous measurement pacing
	sucp_pkg::sucp_auto_st_t am_ff;
	logic [31:0] tick_ff;
	logic [3:0] step_ff;
	logic auto_start_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			am_ff <= sucp_pkg::AM_IDLE;
			tick_ff <= 32'h0;
			step_ff <= 4'h0;
			auto_start_ff <= 1'b0;
		end else begin
			auto_start_ff <= 1'b0;
			if (cfg.operating_config.meas_delay == 4'h0) begin
				am_ff <= sucp_pkg::AM_IDLE; // R12
			end else begin
				case (am_ff)
					sucp_pkg::AM_IDLE: begin
						auto_start_ff <= 1'b1; // R13
						am_ff <= sucp_pkg::AM_MEAS;
					end
					sucp_pkg::AM_MEAS: begin
						if (meas_done) begin
							tick_ff <= 32'h0; // R13
							step_ff <= 4'h0;
							am_ff <= sucp_pkg::AM_WAIT;
						end
					end
					sucp_pkg::AM_WAIT: begin
						if (tick_ff == 32'(STEP_CYCLES - 1)) begin
							tick_ff <= 32'h0;
							if (step_ff + 4'h1 >= cfg.operating_config.meas_delay) begin
								auto_start_ff <= 1'b1; // R12
								am_ff <= sucp_pkg::AM_MEAS;
							end else begin
								step_ff <= step_ff + 4'h1;
							end
						end else begin
							tick_ff <= tick_ff + 32'h1;
						end
					end
					default: am_ff <= sucp_pkg::AM_IDLE;
				endcase
			end
		end
	end

	assign auto_start = auto_start_ff;

	// link domain: bits are taken on rising scl, driven on falling scl
	sucp_pkg::sucp_link_st_t st_ff;
	logic [2:0] bit_ff;
	logic [7:0] sh_ff;
	logic [1:0] byte_ff;
	logic rw_ff;
	logic [7:0] wdat_hi_ff;
	logic [7:0] wdat_lo_ff;
	logic [6:0] dev_ls_ff [2];
	logic [1:0] crc_ls_ff;
	logic [7:0] rx;
	logic [7:0] rd_byte;
	logic commit_ptr;
	logic commit_data;
	logic crc_on;

	assign rx = {sh_ff[6:0], sda_i};
	assign crc_on = crc_ls_ff[1];
	assign commit_ptr = (st_ff == sucp_pkg::LK_CMD) && (bit_ff == 3'h7);
	assign commit_data = (st_ff == sucp_pkg::LK_WDATA) && (bit_ff == 3'h7)
		&& (((byte_ff == 2'h1) && !crc_on) || ((byte_ff == 2'h2)
		&& crc_on && (crc8({wdat_hi_ff, wdat_lo_ff}) == rx))); // R19

	// address and checksum enable are static during a frame
	always_ff @(posedge scl or posedge link_idle_ff) begin
		if (link_idle_ff) begin
			dev_ls_ff[0] <= 7'h00;
			dev_ls_ff[1] <= 7'h00;
			crc_ls_ff <= 2'h0;
		end else begin
			dev_ls_ff[0] <= dev_addr_ff;
			dev_ls_ff[1] <= dev_ls_ff[0];
			crc_ls_ff <= {crc_ls_ff[0], cfg.inten.link_crc_en};
		end
	end

	always_ff @(posedge scl or posedge link_idle_ff) begin
		if (link_idle_ff) begin
			st_ff <= sucp_pkg::LK_ADDR;
			bit_ff <= 3'h0;
			sh_ff <= 8'h00;
			byte_ff <= 2'h0;
			rw_ff <= 1'b0;
			wdat_hi_ff <= 8'h00;
			wdat_lo_ff <= 8'h00;
		end else begin
			case (st_ff)
				sucp_pkg::LK_ADDR: begin
					sh_ff <= rx;
					bit_ff <= bit_ff + 3'h1;
					if (bit_ff == 3'h7) begin
						rw_ff <= rx[0];
						if (rx[7:1] == dev_ls_ff[1]) begin
							st_ff <= sucp_pkg::LK_ADDR_ACK; // R17
						end else begin
							st_ff <= sucp_pkg::LK_IGNORE;
						end
					end
				end
				sucp_pkg::LK_ADDR_ACK: begin
					byte_ff <= 2'h0;
					st_ff <= rw_ff ? sucp_pkg::LK_RDATA : sucp_pkg::LK_CMD;
				end
				sucp_pkg::LK_CMD: begin
					sh_ff <= rx;
					bit_ff <= bit_ff + 3'h1;
					if (bit_ff == 3'h7) begin
						st_ff <= sucp_pkg::LK_CMD_ACK;
					end
				end
				sucp_pkg::LK_CMD_ACK: begin
					byte_ff <= 2'h0;
					st_ff <= sucp_pkg::LK_WDATA;
				end
				sucp_pkg::LK_WDATA: begin
					sh_ff <= rx;
					bit_ff <= bit_ff + 3'h1;
					if (bit_ff == 3'h7) begin
						if (byte_ff == 2'h0) begin
							wdat_hi_ff <= rx;
						end
						// the shifter is reused by the checksum byte
						if (byte_ff == 2'h1) begin
							wdat_lo_ff <= rx;
						end
						if ((byte_ff == 2'h2 && !commit_data)
							|| byte_ff == 2'h3 || (byte_ff == 2'h2 && !crc_on)) begin
							st_ff <= sucp_pkg::LK_IGNORE; // R19
						end else begin
							st_ff <= sucp_pkg::LK_WACK;
						end
					end
				end
				sucp_pkg::LK_WACK: begin
					byte_ff <= byte_ff + 2'h1;
					st_ff <= sucp_pkg::LK_WDATA;
				end
				sucp_pkg::LK_RDATA: begin
					bit_ff <= bit_ff + 3'h1;
					if (bit_ff == 3'h7) begin
						st_ff <= sucp_pkg::LK_RACK;
					end
				end
				sucp_pkg::LK_RACK: begin
					if (sda_i || byte_ff == 2'h3) begin
						st_ff <= sucp_pkg::LK_IGNORE;
					end else begin
						byte_ff <= byte_ff + 2'h1;
						st_ff <= sucp_pkg::LK_RDATA;
					end
				end
				default: st_ff <= sucp_pkg::LK_IGNORE;
			endcase
		end
	end

	// the toggle survives frame ends, else a reset would fake a write
	always_ff @(posedge scl or posedge rst) begin
		if (rst) begin
			wr_tog_ff <= 1'b0;
			wr_kind_ff <= 1'b0;
			wr_idx_ff <= 3'h0;
			wr_data_ff <= 16'h0000;
		end else if (commit_ptr) begin
			wr_tog_ff <= ~wr_tog_ff;
			wr_kind_ff <= 1'b0;
			wr_idx_ff <= rx[2:0];
		end else if (commit_data) begin
			wr_tog_ff <= ~wr_tog_ff;
			wr_kind_ff <= 1'b1;
			wr_data_ff <= crc_on ? {wdat_hi_ff, wdat_lo_ff}
				: {wdat_hi_ff, rx};
		end
	end

	// read word is quasi-static: it changes only outside read frames
	always_comb begin
		if (byte_ff == 2'h0) begin
			rd_byte = rd_word_ff[15:8];
		end else if (byte_ff == 2'h1) begin
			rd_byte = rd_word_ff[7:0];
		end else if (byte_ff == 2'h2 && crc_on) begin
			rd_byte = rd_crc_ff; // R19
		end else begin
			rd_byte = `SUCP_RD_IDLE;
		end
	end

	logic oe_n_ff;
	logic sda_o_ff;

	always_ff @(negedge scl or posedge link_idle_ff) begin
		if (link_idle_ff) begin
			oe_n_ff <= 1'b1;
			sda_o_ff <= 1'b0;
		end else begin
			sda_o_ff <= 1'b0;
			case (st_ff)
				sucp_pkg::LK_ADDR_ACK, sucp_pkg::LK_CMD_ACK,
				sucp_pkg::LK_WACK: oe_n_ff <= 1'b0;
				sucp_pkg::LK_RDATA: oe_n_ff <= rd_byte[3'h7 - bit_ff];
				default: oe_n_ff <= 1'b1;
			endcase
		end
	end

	assign sda_o = sda_o_ff;
	assign sda_oe_n = oe_n_ff;

endmodule : sucp_cfg_page
`default_nettype wire

// file: verilog/sucp_defs.svh
// register indices, write masks, reset values and timing constants
`ifndef SUCP_DEFS_SVH
`define SUCP_DEFS_SVH

`define SUCP_IDX_DIG 3'h0
`define SUCP_IDX_PRES 3'h1
`define SUCP_IDX_TEMPA 3'h2
`define SUCP_IDX_TEMPB 3'h3
`define SUCP_IDX_OPERATING_CONFIG 3'h4
`define SUCP_IDX_DAC 3'h5
`define SUCP_IDX_COM 3'h6
`define SUCP_IDX_INTEN 3'h7
`define SUCP_NUM_REGS 8

`define SUCP_MASK_DIG 16'h0001
`define SUCP_MASK_MEAS 16'h0fff
`define SUCP_MASK_OPERATING_CONFIG 16'hffff
`define SUCP_MASK_DAC 16'h3fff
`define SUCP_MASK_COM 16'h00ff
`define SUCP_MASK_INTEN 16'h003f

`define SUCP_RST_ZERO 16'h0000
`define SUCP_RST_COM 16'h00ea

`define SUCP_CLK_HZ 100000000
`define SUCP_DELAY_STEP_S 4
`define SUCP_SPIKE_NS 50

`define SUCP_CRC_POLY 8'h07
`define SUCP_CRC_INIT 8'hff
`define SUCP_RD_IDLE 8'hff

`endif

// file: verilog/sucp_pkg.sv
// types of the user configuration page
`default_nettype none
package sucp_pkg;

	typedef struct packed {
		logic [3:0] oversample_ratio;
		logic [2:0] auto_filter;
		logic [2:0] chopper_sel;
		logic [1:0] result_width;
	} sucp_meas_t;

	typedef struct packed {
		logic [3:0] meas_delay;
		logic [1:0] fifo_policy;
		logic [4:0] fifo_irq_level;
		logic temp_out_sel;
		logic hyst_switch_on;
		logic int_level_mode;
		logic quick_wake;
		logic int_replace_mode;
	} sucp_operating_config_t;

	typedef struct packed {
		logic [2:0] dac_mode;
		logic dac_buff_mode;
		logic [1:0] drv_vdd_sel;
		logic dac_src_temp;
		logic [2:0] dac_clip_lo;
		logic [2:0] dac_clip_hi;
		logic dac_offset_comp_off;
	} sucp_dac_t;

	typedef struct packed {
		logic [5:0] addr_hi;
		logic spike_filter_on;
		logic chain_mode_on;
	} sucp_com_t;

	typedef struct packed {
		logic sensor_err_en;
		logic calc_err_en;
		logic adc_err_en;
		logic mem_crc_en;
		logic link_crc_en;
		logic global_int_en;
	} sucp_inten_t;

	typedef struct packed {
		logic restore_on_fault;
		sucp_meas_t pres;
		sucp_meas_t temp_a;
		sucp_meas_t temp_b;
		sucp_operating_config_t operating_config;
		sucp_dac_t dac;
		sucp_com_t com;
		sucp_inten_t inten;
	} sucp_cfg_t;

	typedef struct packed {
		logic thr_evt;
		logic adc_done;
		logic adc_err;
		logic calc_err;
		logic sensor_err;
	} sucp_evt_t;

	typedef enum logic [8:0] {
		LK_ADDR = 9'h001,
		LK_ADDR_ACK = 9'h002,
		LK_CMD = 9'h004,
		LK_CMD_ACK = 9'h008,
		LK_WDATA = 9'h010,
		LK_WACK = 9'h020,
		LK_RDATA = 9'h040,
		LK_RACK = 9'h080,
		LK_IGNORE = 9'h100
	} sucp_link_st_t;

	typedef enum logic [2:0] {
		AM_IDLE = 3'h1,
		AM_MEAS = 3'h2,
		AM_WAIT = 3'h4
	} sucp_auto_st_t;

endpackage : sucp_pkg
`default_nettype wire

// file: verif/sucp_cfg_page_checker.sv
// assertions on the configuration page ports
`default_nettype none
module sucp_cfg_page_checker #(
	parameter int unsigned STEP_CYCLES = 10
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// inputs of the page
	input wire logic chip_select_pin,
	input wire logic [7:0][15:0] nvm_image,
	input wire logic conv_req,
	input wire logic mem_crc_fail,
	input wire logic meas_done,
	input wire sucp_pkg::sucp_evt_t evt,
	// outputs of the page
	input wire sucp_pkg::sucp_cfg_t cfg,
	input wire logic [6:0] dev_addr,
	input wire logic auto_start,
	input wire logic fifo_enable,
	input wire logic fifo_overwrite,
	input wire logic int_pin
);
	logic wait_ff;
	logic [31:0] gap_ff;
	logic [31:0] span;
	assign span = 32'(cfg.operating_config.meas_delay) * STEP_CYCLES;

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// a pause is open from each finished measurement to the next start
	always_ff @(posedge clk_sys) begin
		if (rst || auto_start)
			wait_ff <= 1'b0;
		else if (meas_done)
			wait_ff <= 1'b1;
	end
	always_ff @(posedge clk_sys) begin
		if (rst || meas_done)
			gap_ff <= 32'h0;
		else
			gap_ff <= gap_ff + 32'h1;
	end

	chk_fifo_on: assert property (
		$stable(cfg.operating_config.fifo_policy) |->
		fifo_enable == (cfg.operating_config.fifo_policy != 2'h0))
		else $error("fifo enable wrong");
	chk_fifo_wrap: assert property (
		$stable(cfg.operating_config.fifo_policy) |->
		fifo_overwrite == cfg.operating_config.fifo_policy[1])
		else $error("fifo overwrite wrong");
	chk_addr_map: assert property (
		(!$changed(chip_select_pin) && !$changed(cfg.com.addr_hi))[*8]
		|-> dev_addr == {cfg.com.addr_hi, !chip_select_pin})
		else $error("bus address wrong");
	chk_gate_off: assert property (
		!cfg.inten.global_int_en[*2] |-> !int_pin)
		else $error("interrupt passed closed gate");
	chk_pulse_cause: assert property (
		!cfg.operating_config.int_level_mode && !$past(cfg.operating_config.int_level_mode) &&
		cfg.operating_config.fifo_irq_level == 5'h00 &&
		$past(cfg.operating_config.fifo_irq_level) == 5'h00 && int_pin |->
		$past(evt) != 5'h00)
		else $error("interrupt pulse without event");
	chk_err_gate: assert property (
		evt == 5'h04 && !cfg.inten.adc_err_en &&
		!cfg.operating_config.int_level_mode && cfg.operating_config.fifo_irq_level == 5'h00
		|=> !int_pin)
		else $error("masked error raised interrupt");
	chk_auto_first: assert property (
		$rose(|cfg.operating_config.meas_delay) |-> ##[0:2] auto_start)
		else $error("autonomous start missing");
	chk_auto_early: assert property (
		auto_start && wait_ff |-> gap_ff + 32'h3 >= span)
		else $error("measurement pause too short");
	chk_auto_late: assert property (
		wait_ff && span != 32'h0 |-> gap_ff <= span + 32'h4)
		else $error("measurement pause too long");
	chk_reload: assert property (
		conv_req && mem_crc_fail && cfg.inten.mem_crc_en &&
		cfg.restore_on_fault |=> cfg.pres == nvm_image[1][11:0])
		else $error("restore from memory missing");
endmodule : sucp_cfg_page_checker

bind sucp_cfg_page sucp_cfg_page_checker #(.STEP_CYCLES(STEP_CYCLES)) i_chk (
	.clk_sys(clk_sys), .rst(rst), .chip_select_pin(chip_select_pin),
	.nvm_image(nvm_image), .conv_req(conv_req),
	.mem_crc_fail(mem_crc_fail), .meas_done(meas_done), .evt(evt),
	.cfg(cfg), .dev_addr(dev_addr), .auto_start(auto_start),
	.fifo_enable(fifo_enable), .fifo_overwrite(fifo_overwrite),
	.int_pin(int_pin)
);
`default_nettype wire

// file: verif/sucp_host_model.sv
// two-wire host that owns the link clock and the host side of data
`default_nettype none
module sucp_host_model (
	// link wires
	output logic scl,
	output wire logic sda,
	input wire logic sda_o,
	input wire logic sda_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sda_h = 1'b1;
	logic ack_ok;
	// pull-up line: high unless someone pulls it down
	assign sda = sda_h & (sda_oe_n | sda_o);
	initial scl = 1'b1;

	task automatic bitx(input logic b, output logic r);
		sda_h = b;
		#8 scl = 1'b1;
		#16 r = sda;
		scl = 1'b0;
		#8;
	endtask : bitx
	task automatic start;
		ack_ok = 1'b1;
		sda_h = 1'b0;
		#48 scl = 1'b0;
		#8;
	endtask : start
	// clock parks high between frames; the gap covers the idle spacing
	task automatic stop;
		sda_h = 1'b0;
		#8 scl = 1'b1;
		#16 sda_h = 1'b1;
		#200;
	endtask : stop
	task automatic tx(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		if (r !== 1'b0)
			ack_ok = 1'b0;
	endtask : tx
	task automatic rx(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(last, r);
	endtask : rx
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8
	// crc: 0 none, 1 good checksum, 2 corrupted checksum
	task automatic wr(input logic [6:0] a, input logic [2:0] w,
		input logic [15:0] v, input logic [1:0] crc);
		start();
		tx({a, 1'b0});
		tx({5'h00, w});
		tx(v[15:8]);
		tx(v[7:0]);
		if (crc != 2'd0)
			tx(crc8(v) ^ {8{crc[1]}});
		stop();
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [2:0] w,
		output logic [15:0] v);
		start();
		tx({a, 1'b0});
		tx({5'h00, w});
		stop();
		start();
		tx({a, 1'b1});
		rx(1'b0, v[15:8]);
		rx(1'b1, v[7:0]);
		stop();
	endtask : rd
	// read with the checksum byte that follows the word
	task automatic rdc(input logic [6:0] a, input logic [2:0] w,
		output logic [15:0] v, output logic [7:0] c);
		start();
		tx({a, 1'b0});
		tx({5'h00, w});
		stop();
		start();
		tx({a, 1'b1});
		rx(1'b0, v[15:8]);
		rx(1'b0, v[7:0]);
		rx(1'b1, c);
		stop();
	endtask : rdc
endmodule : sucp_host_model
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the user configuration page
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] dev_a = 7'h75;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic chip_select_pin = 1'b0;
	logic conv_req = 1'b0;
	logic mem_crc_fail = 1'b0;
	logic meas_done = 1'b0;
	logic int_clear = 1'b0;
	logic [5:0] fifo_count = 6'h00;
	sucp_pkg::sucp_evt_t evt = 5'h00;
	logic [7:0][15:0] nvm_image = {16'h0000, 16'h00ea, 64'h0, 16'h0123,
		16'h0001};
	wire logic scl;
	wire logic sda;
	logic sda_o;
	logic sda_oe_n;
	sucp_pkg::sucp_cfg_t cfg;
	logic [6:0] dev_addr;
	logic auto_start;
	logic fifo_enable;
	logic fifo_overwrite;
	logic int_pin;
	int num_errors = 0;
	int comparisons = 0;
	int n_auto = 0;
	int n_int = 0;

	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (auto_start === 1'b1) n_auto++;
	always @(posedge clk_sys) if (int_pin === 1'b1) n_int++;

	sucp_cfg_page #(.STEP_CYCLES(10)) i_dut (
		.clk_sys(clk_sys), .rst(rst), .scl(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n),
		.chip_select_pin(chip_select_pin), .nvm_image(nvm_image),
		.conv_req(conv_req), .mem_crc_fail(mem_crc_fail),
		.meas_done(meas_done), .fifo_count(fifo_count), .evt(evt),
		.int_clear(int_clear), .cfg(cfg), .dev_addr(dev_addr),
		.auto_start(auto_start), .fifo_enable(fifo_enable),
		.fifo_overwrite(fifo_overwrite), .int_pin(int_pin)
	);
	sucp_host_model i_host (
		.scl(scl), .sda(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
	);

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task automatic pulse(input logic [4:0] e, input logic c);
		@(posedge clk_sys);
		evt <= e;
		int_clear <= c;
		@(posedge clk_sys);
		evt <= 5'h00;
		int_clear <= 1'b0;
		cyc(3);
	endtask : pulse
	task automatic stop_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	task automatic t_reset;
		logic [15:0] v;
		cyc(10);
		cmp(16'(cfg.com), 16'h00ea);
		cmp(16'(|(cfg >> 14)), 16'h0);
		cmp(16'(cfg.inten), 16'h0);
		cmp(16'(sda_o), 16'h0);
		cmp(16'(dev_addr), 16'(dev_a));
		i_host.rd(dev_a, 3'h6, v);
		cmp(v, 16'h00ea);
		cmp(16'(i_host.ack_ok), 16'h1);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_regs;
		logic [15:0] v;
		logic [15:0] m [6] = '{16'h0001, 16'h0fff, 16'h0fff, 16'h0fff,
			16'hffff, 16'h3fff};
		for (int i = 0; i < 6; i++) begin
			i_host.wr(dev_a, 3'(i), 16'hffff, 2'd0);
			i_host.rd(dev_a, 3'(i), v);
			cmp(v, m[i]);
			i_host.wr(dev_a, 3'(i), 16'h0000, 2'd0);
		end
		i_host.wr(dev_a, 3'h2, 16'h0b2e, 2'd0);
		cmp(16'(cfg.temp_a.result_width), 16'h2);
		cmp(16'(cfg.temp_a.chopper_sel), 16'h3);
		cmp(16'(cfg.temp_a.auto_filter), 16'h1);
		cmp(16'(cfg.temp_a.oversample_ratio), 16'hb);
		for (int p = 0; p < 4; p++) begin
			i_host.wr(dev_a, 3'h4, 16'(p) << 10, 2'd0);
			cmp(16'(fifo_enable), 16'(p != 0));
			cmp(16'(fifo_overwrite), 16'(p / 2));
		end
		$display("t_regs done");
	endtask : t_regs
	task automatic t_addr;
		logic [15:0] v;
		i_host.wr(dev_a, 3'h6, 16'h00a9, 2'd0);
		cyc(8);
		cmp(16'(cfg.com.chain_mode_on), 16'h1);
		cmp(16'(cfg.com.spike_filter_on), 16'h0);
		cmp(16'(dev_addr), 16'h0055);
		chip_select_pin <= 1'b1;
		cyc(8);
		cmp(16'(dev_addr), 16'h0054);
		i_host.rd(dev_a, 3'h6, v);
		cmp(16'(i_host.ack_ok), 16'h0);
		i_host.rd(7'h54, 3'h6, v);
		cmp(v, 16'h00a9);
		i_host.wr(7'h54, 3'h6, 16'h00ea, 2'd0);
		chip_select_pin <= 1'b0;
		cyc(8);
		cmp(16'(dev_addr), 16'(dev_a));
		$display("t_addr done");
	endtask : t_addr
	task automatic t_crc;
		logic [15:0] v;
		logic [7:0] c;
		i_host.wr(dev_a, 3'h7, 16'h0002, 2'd0);
		i_host.wr(dev_a, 3'h1, 16'h0abc, 2'd2);
		cmp(16'(cfg.pres), 16'h0000);
		i_host.wr(dev_a, 3'h1, 16'h0abc, 2'd1);
		cmp(16'(cfg.pres), 16'h0abc);
		i_host.rdc(dev_a, 3'h1, v, c);
		cmp(v, 16'h0abc);
		cmp(16'(c), 16'(i_host.crc8(16'h0abc)));
		i_host.wr(dev_a, 3'h7, 16'h0000, 2'd1);
		i_host.wr(dev_a, 3'h1, 16'h0000, 2'd0);
		cmp(16'(cfg.pres), 16'h0000);
		$display("t_crc done");
	endtask : t_crc
	task automatic t_irq;
		i_host.wr(dev_a, 3'h7, 16'h0001, 2'd0);
		i_host.wr(dev_a, 3'h4, 16'h0004, 2'd0);
		pulse(5'h08, 1'b0);
		cyc(3);
		cmp(16'(int_pin), 16'h1);
		pulse(5'h00, 1'b1);
		cmp(16'(int_pin), 16'h0);
		i_host.wr(dev_a, 3'h4, 16'h0000, 2'd0);
		n_int = 0;
		pulse(5'h04, 1'b0);
		cmp(16'(int_pin), 16'h0);
		cmp(16'(n_int), 16'h0);
		pulse(5'h08, 1'b0);
		cmp(16'(int_pin), 16'h0);
		cmp(16'(n_int), 16'h1);
		i_host.wr(dev_a, 3'h4, 16'h0064, 2'd0);
		@(posedge clk_sys);
		fifo_count <= 6'h03;
		cyc(4);
		cmp(16'(int_pin), 16'h1);
		fifo_count <= 6'h00;
		pulse(5'h00, 1'b1);
		i_host.wr(dev_a, 3'h4, 16'h0004, 2'd0);
		i_host.wr(dev_a, 3'h7, 16'h0009, 2'd0);
		pulse(5'h04, 1'b0);
		cmp(16'(int_pin), 16'h1);
		pulse(5'h00, 1'b1);
		i_host.wr(dev_a, 3'h7, 16'h0000, 2'd0);
		pulse(5'h08, 1'b0);
		cmp(16'(int_pin), 16'h0);
		$display("t_irq done");
	endtask : t_irq
	task automatic t_auto;
		n_auto = 0;
		i_host.wr(dev_a, 3'h4, 16'h1000, 2'd0);
		cmp(16'(n_auto), 16'h1);
		@(posedge clk_sys);
		meas_done <= 1'b1;
		@(posedge clk_sys);
		meas_done <= 1'b0;
		cyc(6);
		cmp(16'(n_auto), 16'h1);
		cyc(10);
		cmp(16'(n_auto), 16'h2);
		i_host.wr(dev_a, 3'h4, 16'h0000, 2'd0);
		@(posedge clk_sys);
		meas_done <= 1'b1;
		@(posedge clk_sys);
		meas_done <= 1'b0;
		cyc(40);
		cmp(16'(n_auto), 16'h2);
		$display("t_auto done");
	endtask : t_auto
	task automatic t_reload;
		i_host.wr(dev_a, 3'h0, 16'h0001, 2'd0);
		i_host.wr(dev_a, 3'h7, 16'h0004, 2'd0);
		@(posedge clk_sys);
		conv_req <= 1'b1;
		@(posedge clk_sys);
		conv_req <= 1'b0;
		cyc(3);
		cmp(16'(cfg.inten), 16'h0004);
		@(posedge clk_sys);
		conv_req <= 1'b1;
		mem_crc_fail <= 1'b1;
		@(posedge clk_sys);
		conv_req <= 1'b0;
		mem_crc_fail <= 1'b0;
		cyc(3);
		cmp(16'(cfg.pres), 16'h0123);
		cmp(16'(cfg.inten), 16'h0000);
		$display("t_reload done");
	endtask : t_reload

	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_addr();
		t_crc();
		t_irq();
		t_auto();
		t_reload();
		stop_test();
	end
	// the sequence needs roughly 75 us; allow over five times that
	initial begin
		#400us;
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
